// ---- scrr_host.sv ----
// Host processor model that issues APB transfers to the register block.
`timescale 1ns/1ps
module scrr_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic tmo
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tmo = 1'b0;
  end
  // The wait is bounded so that a slave which never answers cannot hang the run.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    tmo = (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- scrr_pkg.sv ----
// Package with register offsets, field positions and reset values of the channel read-status block.
package scrr_pkg;
  localparam logic [7:0] CHA_RX_STATUS_OFF = 8'h00;
  localparam logic [7:0] CHA_VECTOR_OFF = 8'h04;
  localparam logic [7:0] CHA_PENDING_OFF = 8'h08;
  localparam logic [7:0] CHA_MODE_OFF = 8'h0c;
  localparam logic [7:0] CHB_RX_STATUS_OFF = 8'h10;
  localparam logic [7:0] CHB_VECTOR_OFF = 8'h14;
  localparam logic [7:0] CHB_PENDING_OFF = 8'h18;
  localparam logic [7:0] CHB_MODE_OFF = 8'h1c;
  localparam logic [7:0] EXT_CTRL_OFF = 8'h20;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h24;
  localparam logic [7:0] IRQ_ENABLE_OFF = 8'h28;
  localparam logic [7:0] IRQ_CLEAR_OFF = 8'h2c;

  localparam int EXT_READBACK_BIT = 6;
  localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
  localparam logic [4:0] IRQ_RESET = 5'h00;

  localparam int PEND_B_EXT = 0;
  localparam int PEND_B_TX = 1;
  localparam int PEND_B_RX = 2;
  localparam int PEND_A_EXT = 3;
  localparam int PEND_A_TX = 4;
  localparam int PEND_A_RX = 5;

  localparam int RXS_PARITY = 4;
  localparam int RXS_OVERRUN = 5;
  localparam int RXS_CRC = 6;
  localparam int RXS_EOF = 7;

  localparam int EV_PARITY = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_CRC = 2;
  localparam int EV_EOF = 3;
  localparam int EV_PENDING = 4;

  localparam logic [2:0] VEC_B_TX = 3'h0;
  localparam logic [2:0] VEC_B_EXT = 3'h1;
  localparam logic [2:0] VEC_B_RX = 3'h2;
  localparam logic [2:0] VEC_NONE = 3'h3;
  localparam logic [2:0] VEC_A_TX = 3'h4;
  localparam logic [2:0] VEC_A_EXT = 3'h5;
  localparam logic [2:0] VEC_A_RX = 3'h6;
endpackage

// ---- scrr_top.sv ----
// Read-only status, vector, pending and mode readback registers of serial channels A and B, on APB.
//
// Functional notes
// - Pending bits: B ext,tx,rx then A; 7:6 zero.
// - Pending read via channel B: bits 5:0 zero.
// - Mode bits 5:4 give sync mode.
// - Mode bit 1 parity sense, bit 0 enable.
// - Mode bits 7:6 give clock multiplier.
// - Extended bit 6 enables mode readback.
// - Vector: A unmodified, B status modified.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
module scrr_top (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] RX_STATUS,
  input wire logic [5:0] IP_PEND,
  input wire logic [7:0] MODE_CONFIG,
  input wire logic [7:0] PRIMARY_STATUS,
  input wire logic [7:0] VECTOR_BASE,
  output logic IRQ
);

  logic rst_meta_b;
  logic rst_b;
  logic [7:0] ext_ctrl;
  logic [4:0] irq_status;
  logic [4:0] irq_enable;
  logic [7:0] rx_prev;
  logic [5:0] pend_prev;
  logic [4:0] events;
  logic [4:0] irq_clear;
  logic [7:0] mode_view;
  logic [7:0] vector_mod;
  logic [2:0] vec_code;
  logic [31:0] next_rdata;
  logic next_err;
  logic setup;
  logic wr_done;
  logic readback_on;

  // Release of the reset is synchronised; assertion stays asynchronous.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_b <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_b <= rst_meta_b;
    end
  end

  assign setup = PSEL && !PENABLE;
  assign wr_done = PSEL && PENABLE && PWRITE;
  // Read data is captured in the setup cycle, so the access phase always lasts one cycle.
  assign PREADY = 1'b1;
  assign readback_on = ext_ctrl[scrr_pkg::EXT_READBACK_BIT];

  // Readback shows the configured mode only when enabled; otherwise the primary status is shown.
  always_comb begin
    if (ext_ctrl[scrr_pkg::EXT_READBACK_BIT]) begin
      mode_view = MODE_CONFIG;
    end else begin
      mode_view = PRIMARY_STATUS;
    end
  end

  // Highest-priority pending source picks the code placed in vector bits 3:1.
  always_comb begin
    if (IP_PEND[scrr_pkg::PEND_A_RX]) begin
      vec_code = scrr_pkg::VEC_A_RX;
    end else if (IP_PEND[scrr_pkg::PEND_A_TX]) begin
      vec_code = scrr_pkg::VEC_A_TX;
    end else if (IP_PEND[scrr_pkg::PEND_A_EXT]) begin
      vec_code = scrr_pkg::VEC_A_EXT;
    end else if (IP_PEND[scrr_pkg::PEND_B_RX]) begin
      vec_code = scrr_pkg::VEC_B_RX;
    end else if (IP_PEND[scrr_pkg::PEND_B_TX]) begin
      vec_code = scrr_pkg::VEC_B_TX;
    end else if (IP_PEND[scrr_pkg::PEND_B_EXT]) begin
      vec_code = scrr_pkg::VEC_B_EXT;
    end else begin
      vec_code = scrr_pkg::VEC_NONE;
    end
    vector_mod = {VECTOR_BASE[7:4], vec_code, VECTOR_BASE[0]};
  end

  // Read decode; reads of write-only or unmapped words return zero.
  always_comb begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    unique case (PADDR)
      scrr_pkg::CHA_RX_STATUS_OFF, scrr_pkg::CHB_RX_STATUS_OFF: begin
        next_rdata[7:0] = RX_STATUS;
      end
      scrr_pkg::CHA_VECTOR_OFF: begin
        next_rdata[7:0] = VECTOR_BASE;
      end
      scrr_pkg::CHB_VECTOR_OFF: begin
        next_rdata[7:0] = vector_mod;
      end
      scrr_pkg::CHA_PENDING_OFF: begin
        next_rdata[7:0] = {2'b00, IP_PEND};
      end
      scrr_pkg::CHB_PENDING_OFF: begin
        next_rdata[7:0] = 8'h00;
      end
      scrr_pkg::CHA_MODE_OFF, scrr_pkg::CHB_MODE_OFF: begin
        next_rdata[7:0] = mode_view;
      end
      scrr_pkg::EXT_CTRL_OFF: begin
        next_rdata[7:0] = ext_ctrl;
      end
      scrr_pkg::IRQ_STATUS_OFF: begin
        next_rdata[4:0] = irq_status;
      end
      scrr_pkg::IRQ_ENABLE_OFF: begin
        next_rdata[4:0] = irq_enable;
      end
      scrr_pkg::IRQ_CLEAR_OFF: begin
        next_rdata = 32'h00000000;
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_b) begin
    if (!rst_b) begin
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA <= PWRITE ? 32'h00000000 : next_rdata;
      PSLVERR <= next_err;
    end
  end

  // Only the control, enable and clear words accept data; writes to the status views fall through.
  always_ff @(posedge REF_CLK or negedge rst_b) begin
    if (!rst_b) begin
      ext_ctrl <= scrr_pkg::EXT_CTRL_RESET;
    end else if (wr_done && PADDR == scrr_pkg::EXT_CTRL_OFF) begin
      ext_ctrl <= PWDATA[7:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_b) begin
    if (!rst_b) begin
      irq_enable <= scrr_pkg::IRQ_RESET;
    end else if (wr_done && PADDR == scrr_pkg::IRQ_ENABLE_OFF) begin
      irq_enable <= PWDATA[4:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_b) begin
    if (!rst_b) begin
      rx_prev <= 8'h00;
      pend_prev <= 6'h00;
    end else begin
      rx_prev <= RX_STATUS;
      pend_prev <= IP_PEND;
    end
  end

  assign events[scrr_pkg::EV_PARITY] = RX_STATUS[scrr_pkg::RXS_PARITY] && !rx_prev[scrr_pkg::RXS_PARITY];
  assign events[scrr_pkg::EV_OVERRUN] = RX_STATUS[scrr_pkg::RXS_OVERRUN] && !rx_prev[scrr_pkg::RXS_OVERRUN];
  assign events[scrr_pkg::EV_CRC] = RX_STATUS[scrr_pkg::RXS_CRC] && !rx_prev[scrr_pkg::RXS_CRC];
  assign events[scrr_pkg::EV_EOF] = RX_STATUS[scrr_pkg::RXS_EOF] && !rx_prev[scrr_pkg::RXS_EOF];
  assign events[scrr_pkg::EV_PENDING] = |(IP_PEND & ~pend_prev);
  assign irq_clear = (wr_done && PADDR == scrr_pkg::IRQ_CLEAR_OFF) ? PWDATA[4:0] : 5'h00;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge REF_CLK or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= scrr_pkg::IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | events;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_b) begin
    if (!rst_b) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |((irq_status & ~irq_clear | events) & irq_enable);
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!rst_b);

  sequence rd_at(logic [7:0] off);
    PSEL && !PENABLE && !PWRITE && PADDR == off;
  endsequence

  a_pend_a_map: assert property (rd_at(scrr_pkg::CHA_PENDING_OFF) ##1 PENABLE |->
    PRDATA[7:0] == {2'b00, $past(IP_PEND)})
    else $error("Channel A pending word does not match pending lines.");

  a_pend_b_zero: assert property (rd_at(scrr_pkg::CHB_PENDING_OFF) ##1 PENABLE |->
    PRDATA[5:0] == 6'h00)
    else $error("Channel B pending word shows pending bits.");

  a_mode_readback: assert property (rd_at(scrr_pkg::CHA_MODE_OFF) ##0 readback_on ##1 PENABLE |->
    PRDATA[7:0] == $past(MODE_CONFIG))
    else $error("Mode readback differs from configured mode.");

  a_mode_fields: assert property (rd_at(scrr_pkg::CHB_MODE_OFF) ##0 readback_on ##1 PENABLE |->
    PRDATA[7:6] == $past(MODE_CONFIG[7:6]) && PRDATA[5:4] == $past(MODE_CONFIG[5:4])
    && PRDATA[1:0] == $past(MODE_CONFIG[1:0]))
    else $error("Mode fields misplaced in channel B view.");

  a_mode_hidden: assert property (rd_at(scrr_pkg::CHA_MODE_OFF) ##0 !readback_on ##1 PENABLE |->
    PRDATA[7:0] == $past(PRIMARY_STATUS))
    else $error("Mode shown while readback is disabled.");

  a_vector_plain: assert property (rd_at(scrr_pkg::CHA_VECTOR_OFF) ##1 PENABLE |->
    PRDATA[7:0] == $past(VECTOR_BASE))
    else $error("Channel A vector was modified.");

  a_vector_mod: assert property (rd_at(scrr_pkg::CHB_VECTOR_OFF) ##1 PENABLE |->
    PRDATA[7:4] == $past(VECTOR_BASE[7:4]) && PRDATA[0] == $past(VECTOR_BASE[0])
    && ($past(IP_PEND[5]) -> PRDATA[3:1] == scrr_pkg::VEC_A_RX)
    && ($past(IP_PEND) == 6'h00 -> PRDATA[3:1] == scrr_pkg::VEC_NONE))
    else $error("Channel B vector status bits wrong.");

  a_status_ro: assert property (wr_done && PADDR < scrr_pkg::EXT_CTRL_OFF |=>
    $stable(ext_ctrl) && $stable(irq_enable))
    else $error("Write to a read-only word changed state.");

  a_set_wins: assert property (events[0] && irq_clear[0] |=> irq_status[0])
    else $error("Event lost against a clear.");

  a_irq_level: assert property (##1 IRQ == |(irq_status & $past(irq_enable)))
    else $error("Interrupt output does not follow enabled status.");

  a_single_wait: assert property (PSEL && PENABLE |-> PREADY)
    else $error("Access phase not answered at once.");

  // Views are compared with the inputs as they stood in the setup cycle, since that is when data is captured.
  a_pend_top_zero: assert property (setup && !PWRITE &&
    (PADDR == scrr_pkg::CHA_PENDING_OFF || PADDR == scrr_pkg::CHB_PENDING_OFF) |=>
    PRDATA[7:6] == 2'b00)
    else $error("Unused pending bits read as one.");

  a_mode_b_hidden: assert property (rd_at(scrr_pkg::CHB_MODE_OFF) ##0 !readback_on ##1 PENABLE |->
    PRDATA[7:0] == $past(PRIMARY_STATUS))
    else $error("Channel B mode shown while readback is disabled.");

  a_mode_parity: assert property (rd_at(scrr_pkg::CHA_MODE_OFF) ##0 readback_on ##1 PENABLE |->
    PRDATA[1] == $past(MODE_CONFIG[1]) && PRDATA[0] == $past(MODE_CONFIG[0]))
    else $error("Parity sense or enable misplaced.");

  a_mode_b_parity: assert property (rd_at(scrr_pkg::CHB_MODE_OFF) ##0 readback_on ##1 PENABLE |->
    PRDATA[1:0] == $past(MODE_CONFIG[1:0]))
    else $error("Parity fields misplaced in channel B view.");

  a_mode_clock: assert property (rd_at(scrr_pkg::CHA_MODE_OFF) ##0 readback_on ##1 PENABLE |->
    PRDATA[7:6] == $past(MODE_CONFIG[7:6]))
    else $error("Clock multiplier field misplaced.");

  a_mode_b_clock: assert property (rd_at(scrr_pkg::CHB_MODE_OFF) ##0 readback_on ##1 PENABLE |->
    PRDATA[7:6] == $past(MODE_CONFIG[7:6]))
    else $error("Clock multiplier misplaced in channel B view.");

  a_vector_b_code: assert property (rd_at(scrr_pkg::CHB_VECTOR_OFF) ##1 PENABLE |->
    ($past(IP_PEND[5:4]) == 2'b01 -> PRDATA[3:1] == scrr_pkg::VEC_A_TX)
    && ($past(IP_PEND[5:3]) == 3'b001 -> PRDATA[3:1] == scrr_pkg::VEC_A_EXT)
    && ($past(IP_PEND[5:2]) == 4'b0001 -> PRDATA[3:1] == scrr_pkg::VEC_B_RX)
    && ($past(IP_PEND[5:1]) == 5'b00001 -> PRDATA[3:1] == scrr_pkg::VEC_B_TX)
    && ($past(IP_PEND) == 6'b000001 -> PRDATA[3:1] == scrr_pkg::VEC_B_EXT))
    else $error("Channel B vector priority code wrong.");

  a_rx_status_view: assert property (setup && !PWRITE &&
    (PADDR == scrr_pkg::CHA_RX_STATUS_OFF || PADDR == scrr_pkg::CHB_RX_STATUS_OFF) |=>
    PRDATA[7:0] == $past(RX_STATUS))
    else $error("Receive status view differs from status lines.");

  // Bus bookkeeping: every read answer stands until the next setup cycle.
  a_rdata_stands: assert property (!setup |=> $stable(PRDATA) && $stable(PSLVERR))
    else $error("Read answer changed outside a setup cycle.");

  a_upper_zero: assert property (setup |=> PRDATA[31:8] == 24'h000000)
    else $error("Upper read data bits not zero.");

  a_write_rdata_zero: assert property (setup && PWRITE |=> PRDATA == 32'h00000000)
    else $error("Write returned read data.");

  a_unmapped_err: assert property (setup && PADDR > scrr_pkg::IRQ_CLEAR_OFF |=>
    PSLVERR && PRDATA == 32'h00000000)
    else $error("Unmapped word not refused.");

  a_mapped_ok: assert property (setup && PADDR <= scrr_pkg::IRQ_CLEAR_OFF && PADDR[1:0] == 2'b00 |=> !PSLVERR)
    else $error("Mapped word answered with an error.");

  a_ext_write: assert property (wr_done && PADDR == scrr_pkg::EXT_CTRL_OFF |=>
    ext_ctrl == $past(PWDATA[7:0]))
    else $error("Extended control write lost.");

  a_enable_write: assert property (wr_done && PADDR == scrr_pkg::IRQ_ENABLE_OFF |=>
    irq_enable == $past(PWDATA[4:0]))
    else $error("Interrupt enable write lost.");

  a_status_write_ro: assert property (wr_done && PADDR == scrr_pkg::IRQ_STATUS_OFF && events == 5'h00 |=>
    irq_status == $past(irq_status))
    else $error("Write to the status word changed it.");

  // Interrupt bookkeeping: events are sticky until written off, and the output needs a cause.
  a_event_sets: assert property (events != 5'h00 |=> (irq_status & $past(events)) == $past(events))
    else $error("Event did not set its status bit.");

  a_clear_works: assert property (irq_clear != 5'h00 |=> (irq_status & $past(irq_clear & ~events)) == 5'h00)
    else $error("Status bit survived its clear.");

  a_irq_masked: assert property (irq_enable == 5'h00 |=> !IRQ)
    else $error("Interrupt raised with every source masked.");

  a_irq_cause: assert property (IRQ |-> irq_status != 5'h00)
    else $error("Interrupt raised with no status bit set.");

  // The default disable would hide the reset state, so these two checks turn it off.
  a_reset_quiet: assert property (@(posedge REF_CLK) disable iff (1'b0) !rst_b |->
    PRDATA == 32'h00000000 && !PSLVERR && !IRQ)
    else $error("Outputs not quiet during reset.");

  a_reset_regs: assert property (@(posedge REF_CLK) disable iff (1'b0) !rst_b |->
    ext_ctrl == scrr_pkg::EXT_CTRL_RESET && irq_enable == scrr_pkg::IRQ_RESET && irq_status == scrr_pkg::IRQ_RESET)
    else $error("Registers not at reset values during reset.");

  c_mode_read: cover property (rd_at(scrr_pkg::CHA_MODE_OFF) ##0 readback_on ##1 PENABLE);
  c_vector_b: cover property (rd_at(scrr_pkg::CHB_VECTOR_OFF) ##0 IP_PEND != 6'h00 ##1 PENABLE);
  c_irq_raise: cover property (!IRQ ##1 IRQ);
  c_set_clear: cover property (events[0] && irq_clear[0]);
  c_unmapped: cover property (setup && PADDR > scrr_pkg::IRQ_CLEAR_OFF ##1 PSLVERR);
endmodule

// ---- serial_ctrl_read_status_regs_bench.sv ----
// Self-checking bench for the channel read-status register block.
`timescale 1ns/1ps
module serial_ctrl_read_status_regs_bench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, tmo, err, ext;
  logic [7:0] paddr;
  logic [7:0] rx_status = 8'h00;
  logic [7:0] mode_config = 8'h00;
  logic [7:0] primary_status = 8'h00;
  logic [7:0] vector_base = 8'h00;
  logic [5:0] ip_pend = 6'h00;
  logic [31:0] pwdata, prdata, rd;
  int fail_count = 0;
  int comparisons = 0;
  always #12.5 ref_clk = ~ref_clk;
  scrr_top DUT (.REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_STATUS(rx_status), .IP_PEND(ip_pend), .MODE_CONFIG(mode_config),
    .PRIMARY_STATUS(primary_status), .VECTOR_BASE(vector_base), .IRQ(irq));
  scrr_host host (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tmo(tmo));
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, rd, err);
    if (tmo) begin
      fail_count++;
      $display("CHECK FAILED at %0t: no answer from slave", $time);
      stop_test();
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp, "read data");
    check({31'h0, err}, 32'h0, "slave error");
  endtask
  // Priority order of the pending sources decides the code placed into the vector.
  function automatic logic [2:0] vcode(input logic [5:0] p);
    if (p[5]) return 3'h6;
    if (p[4]) return 3'h4;
    if (p[3]) return 3'h5;
    if (p[2]) return 3'h2;
    if (p[1]) return 3'h0;
    if (p[0]) return 3'h1;
    return 3'h3;
  endfunction
  task automatic irq_chk(input logic exp, input string msg);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check({31'h0, irq}, {31'h0, exp}, msg);
  endtask
  initial begin
    void'($urandom(32'h75fc));
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_chk(scrr_pkg::EXT_CTRL_OFF, 32'h0);
    rd_chk(scrr_pkg::IRQ_ENABLE_OFF, 32'h0);
    $display("reset test done");
    repeat (40) begin
      @(posedge ref_clk);
      rx_status <= 8'($urandom);
      ip_pend <= 6'($urandom);
      mode_config <= 8'($urandom);
      primary_status <= 8'($urandom);
      vector_base <= 8'($urandom);
      ext = 1'($urandom);
      xfer(1'b1, scrr_pkg::EXT_CTRL_OFF, {25'h0, ext, 6'h0});
      for (int a = 0; a < 32; a += 4) begin
        xfer(1'b1, 8'(a), $urandom);
      end
      rd_chk(scrr_pkg::CHA_RX_STATUS_OFF, {24'h0, rx_status});
      rd_chk(scrr_pkg::CHB_RX_STATUS_OFF, {24'h0, rx_status});
      rd_chk(scrr_pkg::CHA_VECTOR_OFF, {24'h0, vector_base});
      rd_chk(scrr_pkg::CHB_VECTOR_OFF, {24'h0, vector_base[7:4], vcode(ip_pend), vector_base[0]});
      rd_chk(scrr_pkg::CHA_PENDING_OFF, {26'h0, ip_pend});
      rd_chk(scrr_pkg::CHB_PENDING_OFF, 32'h0);
      rd_chk(scrr_pkg::CHA_MODE_OFF, {24'h0, ext ? mode_config : primary_status});
    end
    $display("random read test done");
    xfer(1'b1, scrr_pkg::EXT_CTRL_OFF, 32'h40);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      mode_config <= {2'(i), 2'(3 - i), 2'(i), i[0], ~i[0]};
      rd_chk(scrr_pkg::CHB_MODE_OFF, {24'h0, 2'(i), 2'(3 - i), 2'(i), i[0], ~i[0]});
    end
    xfer(1'b0, 8'h30, 32'h0);
    check({err, rd[30:0]}, 32'h80000000, "unmapped read");
    $display("mode and unmapped test done");
    @(posedge ref_clk);
    rx_status <= 8'h00;
    xfer(1'b1, scrr_pkg::IRQ_CLEAR_OFF, 32'h1f);
    xfer(1'b1, scrr_pkg::IRQ_ENABLE_OFF, 32'h1);
    irq_chk(1'b0, "irq idle");
    @(posedge ref_clk);
    rx_status <= 8'h10;
    irq_chk(1'b1, "irq raised");
    rd_chk(scrr_pkg::IRQ_STATUS_OFF, 32'h1);
    xfer(1'b1, scrr_pkg::IRQ_ENABLE_OFF, 32'h0);
    irq_chk(1'b0, "irq masked");
    xfer(1'b1, scrr_pkg::IRQ_ENABLE_OFF, 32'h1);
    irq_chk(1'b1, "irq unmasked");
    xfer(1'b1, scrr_pkg::IRQ_CLEAR_OFF, 32'h1);
    irq_chk(1'b0, "irq cleared");
    rd_chk(scrr_pkg::IRQ_STATUS_OFF, 32'h0);
    // An event that lands on the clearing edge must survive the clear.
    @(posedge ref_clk);
    rx_status <= 8'h00;
    fork
      xfer(1'b1, scrr_pkg::IRQ_CLEAR_OFF, 32'h1);
      begin
        repeat (2) @(posedge ref_clk);
        rx_status <= 8'h10;
      end
    join
    rd_chk(scrr_pkg::IRQ_STATUS_OFF, 32'h1);
    $display("interrupt test done");
    @(posedge ref_clk);
    rx_status <= 8'h00;
    ip_pend <= 6'h00;
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0, "irq in reset");
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_chk(scrr_pkg::EXT_CTRL_OFF, 32'h0);
    rd_chk(scrr_pkg::IRQ_STATUS_OFF, 32'h0);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule
